//--- hdl/cie_core.sv
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/10ps
module cie_core
  import cie_pkg::*;
(
  // Clock and resets
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        system_init_input_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Instruction boundary from the core
  input  wire logic        instr_done_i,
  input  wire logic        instr_prefix_i,
  input  wire logic        instr_seg_write_i,
  input  wire logic        instr_wait_i,
  input  wire logic        instr_numeric_i,
  input  wire logic [7:0]  opcode_i,
  input  wire logic        esc_prefix_i,
  input  wire logic [15:0] instr_ip_i,
  input  wire logic [15:0] prefix_ip_i,
  input  wire logic [15:0] next_ip_i,
  input  wire logic [15:0] cur_cs_i,
  // Instruction exception causes
  input  wire logic        div_overflow_i,
  input  wire logic        undef_opcode_i,
  input  wire logic        limit_check_i,
  input  wire logic [15:0] limit_index_i,
  input  wire logic [15:0] limit_lo_i,
  input  wire logic [15:0] limit_hi_i,
  input  wire logic        overflow_trap_i,
  input  wire logic        breakpoint_i,
  input  wire logic        soft_int_i,
  input  wire logic [7:0]  soft_type_i,
  input  wire logic        coproc_error_i,
  // Flag traffic
  input  wire logic        int_return_i,
  input  wire logic [15:0] int_return_sw_i,
  input  wire logic        sw_write_i,
  input  wire logic [15:0] sw_data_i,
  // Hardware requests
  input  wire logic        nonmaskable_request_i,
  input  wire logic [2:0]  timer_req_i,
  input  wire logic [1:0]  dma_req_i,
  input  wire logic [3:0]  external_request_lines_i,
  // Vector fetch answer
  input  wire logic        vec_ack_i,
  input  wire logic [15:0] vec_cs_i,
  input  wire logic [15:0] vec_ip_i,
  // Core control
  output logic             core_hold_o,
  output logic             fetch_valid_o,
  output logic      [19:0] fetch_addr_o,
  output logic             push_valid_o,
  output logic      [15:0] push_data_o,
  output logic             vec_req_o,
  output logic      [9:0]  vec_addr_o,
  output logic      [8:0]  src_ack_o,
  output logic      [15:0] status_word_o
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {S_INIT, S_RUN, S_PSW, S_PCS, S_PIP, S_VEC} cie_fsm_type;
  typedef struct packed {
    cie_fsm_type fsm;
    logic [7:0]  cnt;
    logic [15:0] sw;
    logic [15:0] ret_cs;
    logic [15:0] ret_ip;
    logic [7:0]  vtype;
    logic        nmi_pend;
    logic        nmi_q;
    logic        enh;
    logic        slv;
    logic [15:0] reloc;
    logic [15:0] umcs;
    logic [20:0] prio;
    logic [31:0] svec;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        hold;
    logic        fv;
    logic [19:0] faddr;
    logic        pv;
    logic [15:0] pdata;
    logic        vreq;
    logic [9:0]  vaddr;
    logic [8:0]  ack;
  } cie_state_type;

  cie_state_type s;
  cie_state_type next_s;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Segment and offset to physical address
  function automatic logic [19:0] phys(input logic [15:0] seg, input logic [15:0] off);
    phys = {seg, 4'h0} + {4'h0, off};
  endfunction : phys

  // True when every source has its own programmed level
  function automatic logic lvl_unique(input logic [20:0] p);
    lvl_unique = 1'b1;
    for (int i = 0; i < NSRC; i++)
      for (int j = i + 1; j < NSRC; j++)
        if (p[i*LVL_W +: LVL_W] == p[j*LVL_W +: LVL_W])
          lvl_unique = 1'b0;
  endfunction : lvl_unique

  // Winning source index, valid in bit 3
  function automatic logic [3:0] pick(input logic [6:0] req, input logic [20:0] p);
    logic [3:0] best;
    logic [3:0] lvl;
    logic       uq;
    best = 4'h0;
    lvl  = 4'hF;
    uq   = lvl_unique(p);
    for (int i = 0; i < NSRC; i++)
    begin
      // Lower level wins; ties keep the lower index
      if (req[i] && ((uq ? {1'b0, p[i*LVL_W +: LVL_W]} : DEF_PRIO[i*4 +: 4]) < lvl ||
                     !best[3]))
      begin
        lvl  = uq ? {1'b0, p[i*LVL_W +: LVL_W]} : DEF_PRIO[i*4 +: 4];
        best = {1'b1, 3'(i)};
      end
    end
    pick = best;
  endfunction : pick

  // ----------------------------------------
  // Boundary decode
  // ----------------------------------------
  logic        at_bnd;
  logic        is_esc;
  logic        esc_trap;
  logic        lim_fail;
  logic [15:0] base_sw;
  logic [6:0]  mreq;
  logic [3:0]  win;
  logic        exc_any;
  logic        mask_take;
  logic        step_take;

  assign at_bnd   = (s.fsm == S_RUN) && instr_done_i;
  assign is_esc   = (opcode_i >= ESC_LO) && (opcode_i <= ESC_HI);
  assign esc_trap = is_esc && (!s.enh || s.reloc[RELOC_ESC]);
  assign lim_fail = limit_check_i && (($signed(limit_index_i) < $signed(limit_lo_i)) ||
                    ($signed(limit_index_i) > $signed(limit_hi_i)));
  // Flags as they stand after the instruction
  assign base_sw  = int_return_i ? int_return_sw_i : (sw_write_i ? sw_data_i : s.sw);
  assign mreq     = {external_request_lines_i, dma_req_i, |timer_req_i};
  assign win      = pick(mreq, s.prio);
  assign exc_any  = div_overflow_i || undef_opcode_i || esc_trap || lim_fail ||
                    (overflow_trap_i && s.sw[SW_OF]) || breakpoint_i || soft_int_i ||
                    (instr_numeric_i && coproc_error_i);
  assign mask_take = win[3] && base_sw[SW_IF];
  // Suppressed after prefix, segment writes and wait
  assign step_take = s.sw[SW_TF] && !instr_prefix_i && !instr_seg_write_i &&
                     !instr_wait_i;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_s      = s;
    next_s.fv   = 1'b0;
    next_s.pv   = 1'b0;
    next_s.ack  = 9'h000;
    // Edge of the nonmaskable input; a new edge beats the clear
    next_s.nmi_q = nonmaskable_request_i;
    if (nonmaskable_request_i && !s.nmi_q)
      next_s.nmi_pend = 1'b1;

    // APB: setup cycle latches the answer, access cycle completes
    if (psel_i && !penable_i)
    begin
      next_s.pready  = 1'b1;
      next_s.pslverr = 1'b0;
      unique case (paddr_i)
        OFF_CTRL:  next_s.prdata = {30'h0, s.slv, s.enh};
        OFF_RELOC: next_s.prdata = {16'h0, s.reloc};
        OFF_UMCS:  next_s.prdata = {16'h0, s.umcs};
        OFF_PRIO:  next_s.prdata = {11'h0, s.prio};
        OFF_SVEC:  next_s.prdata = s.svec;
        OFF_STAT:  next_s.prdata = {5'h0, 3'(s.fsm), s.vtype, s.sw};
        default:
        begin
          next_s.prdata  = 32'h0000_0000;
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    else if (psel_i && penable_i && s.pready)
    begin
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
      if (pwrite_i && !s.pslverr)
      begin
        if (paddr_i == OFF_CTRL)
        begin
          next_s.enh = pwdata_i[CTRL_ENH];
          next_s.slv = pwdata_i[CTRL_SLV];
        end
        if (paddr_i == OFF_RELOC)
          next_s.reloc = pwdata_i[15:0];
        if (paddr_i == OFF_UMCS)
          next_s.umcs = pwdata_i[15:0];
        if (paddr_i == OFF_PRIO)
          next_s.prio = pwdata_i[20:0];
        if (paddr_i == OFF_SVEC)
          next_s.svec = pwdata_i;
      end
    end

    // Entry sequencer
    unique case (s.fsm)
      S_INIT:
      begin
        next_s.cnt = s.cnt + 8'h01;
        if (s.cnt == 8'(INIT_CYC - 1))
        begin
          next_s.fsm   = S_RUN;
          next_s.hold  = 1'b0;
          next_s.fv    = 1'b1;
          next_s.faddr = phys(CS_RST, IP_RST);
        end
      end
      S_RUN:
      begin
        // Requests are looked at only when an instruction completes
        if (instr_done_i)
        begin
          next_s.sw     = base_sw;
          next_s.ret_cs = cur_cs_i;
          next_s.ret_ip = next_ip_i;
          next_s.fsm    = S_PSW;
          next_s.hold   = 1'b1;
          if (div_overflow_i)
            next_s.vtype = TYPE_DIV;
          else if (undef_opcode_i)
            next_s.vtype = TYPE_UNDEF;
          else if (esc_trap)
          begin
            next_s.vtype  = TYPE_ESC;
            next_s.ret_ip = esc_prefix_i ? prefix_ip_i : instr_ip_i;
          end
          else if (lim_fail)
            next_s.vtype = TYPE_BOUND;
          else if (overflow_trap_i && s.sw[SW_OF])
            next_s.vtype = TYPE_OVF;
          else if (breakpoint_i)
            next_s.vtype = TYPE_BRK;
          else if (instr_numeric_i && coproc_error_i)
            next_s.vtype = TYPE_NUM;
          else if (soft_int_i)
            next_s.vtype = soft_type_i;
          else if (s.nmi_pend)
          begin
            next_s.vtype    = TYPE_NMI;
            next_s.nmi_pend = nonmaskable_request_i && !s.nmi_q;
          end
          else if (mask_take)
          begin
            // Fixed types; timer1, timer2 and dma types programmed in slave mode
            unique case (win[2:0])
              3'd0:
              begin
                if (timer_req_i[0])
                begin
                  next_s.vtype  = TYPE_TMR0;
                  next_s.ack[0] = 1'b1;
                end
                else if (timer_req_i[1])
                begin
                  next_s.vtype  = s.slv ? s.svec[7:0] : TYPE_TMR1;
                  next_s.ack[1] = 1'b1;
                end
                else
                begin
                  next_s.vtype  = s.slv ? s.svec[15:8] : TYPE_TMR2;
                  next_s.ack[2] = 1'b1;
                end
              end
              3'd1:
              begin
                next_s.vtype  = s.slv ? s.svec[23:16] : TYPE_DMA0;
                next_s.ack[3] = 1'b1;
              end
              3'd2:
              begin
                next_s.vtype  = s.slv ? s.svec[31:24] : TYPE_DMA1;
                next_s.ack[4] = 1'b1;
              end
              default:
              begin
                next_s.vtype = TYPE_EXT0 + 8'(win[2:0] - 3'd3);
                next_s.ack[5 + 32'(win[2:0] - 3'd3)] = 1'b1;
              end
            endcase
          end
          else if (step_take)
            next_s.vtype = TYPE_STEP;
          else
          begin
            next_s.fsm  = S_RUN;
            next_s.hold = 1'b0;
          end
        end
      end
      S_PSW:
      begin
        // Status goes out first, then enable and trap flags drop
        next_s.pv    = 1'b1;
        next_s.pdata = s.sw;
        next_s.sw[SW_IF] = 1'b0;
        next_s.sw[SW_TF] = 1'b0;
        next_s.fsm   = S_PCS;
      end
      S_PCS:
      begin
        next_s.pv    = 1'b1;
        next_s.pdata = s.ret_cs;
        next_s.fsm   = S_PIP;
      end
      S_PIP:
      begin
        next_s.pv    = 1'b1;
        next_s.pdata = s.ret_ip;
        next_s.vreq  = 1'b1;
        next_s.vaddr = {s.vtype, 2'b00};
        next_s.fsm   = S_VEC;
      end
      S_VEC:
      begin
        // Hold request until the pointer arrives
        if (vec_ack_i)
        begin
          next_s.vreq  = 1'b0;
          next_s.fv    = 1'b1;
          next_s.faddr = phys(vec_cs_i, vec_ip_i);
          next_s.hold  = 1'b0;
          next_s.fsm   = S_RUN;
        end
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Init input aborts everything, like the clock reset
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || !system_init_input_n_i)
    begin
      s       <= '0;
      s.fsm   <= S_INIT;
      s.hold  <= 1'b1;
      s.sw    <= SW_RST;
      s.reloc <= RELOC_RST;
      s.umcs  <= UMCS_RST;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata_o      = s.prdata;
  assign pready_o      = s.pready;
  assign pslverr_o     = s.pslverr;
  assign core_hold_o   = s.hold;
  assign fetch_valid_o = s.fv;
  assign fetch_addr_o  = s.faddr;
  assign push_valid_o  = s.pv;
  assign push_data_o   = s.pdata;
  assign vec_req_o     = s.vreq;
  assign vec_addr_o    = s.vaddr;
  assign src_ack_o     = s.ack;
  assign status_word_o = s.sw;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i || !system_init_input_n_i);

  a_init_holds_core: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !system_init_input_n_i |=> core_hold_o && !fetch_valid_o && !push_valid_o)
    else $error("activity while init input low");
  a_first_fetch: assert property (s.fsm == S_INIT && next_s.fsm == S_RUN |=>
    fetch_valid_o && fetch_addr_o == FETCH_RST)
    else $error("first fetch address wrong");
  a_reset_words: assert property (s.fsm == S_INIT |-> s.sw == SW_RST)
    else $error("status word not at reset value");
  a_push_order: assert property (s.fsm == S_PSW |=> push_data_o == $past(s.sw)
    ##1 push_data_o == s.ret_cs ##1 push_valid_o && push_data_o == s.ret_ip)
    else $error("push order wrong");
  a_enable_cleared: assert property (s.fsm == S_PSW |=> !s.sw[SW_IF] && !s.sw[SW_TF])
    else $error("flags not cleared on entry");
  a_vector_addr: assert property (s.fsm == S_PIP |=> vec_req_o &&
    vec_addr_o == {s.vtype, 2'b00})
    else $error("vector address wrong");
  a_nmi_type: assert property (at_bnd && s.nmi_pend && !exc_any |=>
    s.vtype == TYPE_NMI ##1 push_valid_o)
    else $error("nonmaskable request not taken");
  a_step_type: assert property (at_bnd && !exc_any && !s.nmi_pend && !mask_take &&
    step_take |=> s.vtype == TYPE_STEP)
    else $error("single step not taken");
  a_masked_off: assert property (at_bnd && !base_sw[SW_IF] |=> src_ack_o == 9'h000)
    else $error("maskable taken while disabled");
  a_overflow: assert property (at_bnd && overflow_trap_i && s.sw[SW_OF] &&
    !div_overflow_i && !undef_opcode_i && !esc_trap && !lim_fail |=>
    s.vtype == TYPE_OVF)
    else $error("overflow trap type wrong");
endmodule : cie_core

//--- hdl/cie_pkg.sv
// Operation
// - Trap flag set raises type 1 after each completed instruction.
// - No step trap after prefix, segment-register write or wait instruction.
// - Step entry clears trap flag; return restores it from saved status word.
// - Breakpoint instruction enters as type 3, table address 12.
// - Fixed maskable types: timer0 8, timers 18/19, dma 10/11, lines 12-15.
// - Programmed levels govern only when all are unique, else defaults.
// - Timers share one level; timer0 above timer1 above timer2.
// - Coprocessor opcodes trap as type 7; enhanced mode needs relocation trap bit.
// - Coprocessor trap returns to the opcode or its segment prefix.
// - Nonmaskable request taken as type 2 regardless of enable; clears enable.
// - Overflow trap instruction with overflow flag set raises type 4.
// - Limit check raises type 5 when index lies outside bounds pair.
// - Undefined opcode raises type 6.
// - Unmasked coprocessor error raises type 16 at next numerics instruction.
// - Maskable requests need enable flag; every entry clears it after save.
// - Interrupt return restores status word including enable flag.
// - Return re-enabling with request pending enters service at once.
// - Slave mode makes timer1, timer2 and dma vector types programmable.
// - While init input is low nothing executes and no bus cycle starts.
// - After init release and a delay, first fetch is at FFFF0.
// - Init loads status word, segments, relocation and upper select resets.
// - Hardware requests sampled only at instruction boundaries, after software.
// - Service pointer fetched from 256-entry table at type times four.
// - Divide quotient overflow raises type 0.
package cie_pkg;
  // ----------------------------------------
  // Vector types
  // ----------------------------------------
  localparam logic [7:0] TYPE_DIV   = 8'h00;
  localparam logic [7:0] TYPE_STEP  = 8'h01;
  localparam logic [7:0] TYPE_NMI   = 8'h02;
  localparam logic [7:0] TYPE_BRK   = 8'h03;
  localparam logic [7:0] TYPE_OVF   = 8'h04;
  localparam logic [7:0] TYPE_BOUND = 8'h05;
  localparam logic [7:0] TYPE_UNDEF = 8'h06;
  localparam logic [7:0] TYPE_ESC   = 8'h07;
  localparam logic [7:0] TYPE_TMR0  = 8'h08;
  localparam logic [7:0] TYPE_DMA0  = 8'h0A;
  localparam logic [7:0] TYPE_DMA1  = 8'h0B;
  localparam logic [7:0] TYPE_EXT0  = 8'h0C;
  localparam logic [7:0] TYPE_NUM   = 8'h10;
  localparam logic [7:0] TYPE_TMR1  = 8'h12;
  localparam logic [7:0] TYPE_TMR2  = 8'h13;
  localparam logic [7:0] ESC_LO     = 8'hD8;
  localparam logic [7:0] ESC_HI     = 8'hDF;
  // ----------------------------------------
  // Status word and reset values
  // ----------------------------------------
  localparam int          SW_TF      = 8;
  localparam int          SW_IF      = 9;
  localparam int          SW_OF      = 11;
  localparam logic [15:0] SW_RST     = 16'hF002;
  localparam logic [15:0] CS_RST     = 16'hFFFF;
  localparam logic [15:0] IP_RST     = 16'h0000;
  localparam logic [15:0] RELOC_RST  = 16'h20FF;
  localparam logic [15:0] UMCS_RST   = 16'hFFFB;
  localparam logic [19:0] FETCH_RST  = 20'hF_FFF0;
  localparam int          RELOC_ESC  = 14;
  // ----------------------------------------
  // Maskable sources: timer group, dma0, dma1, four lines
  // ----------------------------------------
  localparam int          NSRC       = 7;
  localparam int          LVL_W      = 3;
  localparam logic [27:0] DEF_PRIO   = 28'h9876_542;
  // ----------------------------------------
  // APB map
  // ----------------------------------------
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_RELOC  = 12'h004;
  localparam logic [11:0] OFF_UMCS   = 12'h008;
  localparam logic [11:0] OFF_PRIO   = 12'h00C;
  localparam logic [11:0] OFF_SVEC   = 12'h010;
  localparam logic [11:0] OFF_STAT   = 12'h014;
  localparam int          CTRL_ENH   = 0;
  localparam int          CTRL_SLV   = 1;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int          CLK_NS     = 4;
  localparam int          INIT_NS    = 40;
  localparam int          INIT_CYC   = (INIT_NS + CLK_NS - 1) / CLK_NS;
endpackage : cie_pkg

//--- test/cie_vec_table.sv
`timescale 1ns/10ps
module cie_vec_table
(
  // Clock and pointer request from the block
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic [9:0]  addr_i,
  input  wire logic        slow_i,
  // Pointer answer
  output logic             ack_o  = 1'b0,
  output logic      [15:0] cs_o   = 16'h0000,
  output logic      [15:0] ip_o   = 16'h0000
);
  logic [3:0] wait_cnt = 4'h0;

  // -------------------------------------------------
  // Table read: entry at byte address a gives cs=a, ip=~a
  // -------------------------------------------------
  // Idle lines toggle so stale pointer data never looks valid
  always @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    cs_o  <= ~cs_o;
    ip_o  <= cs_o;
    if (req_i && !ack_o)
    begin
      if (wait_cnt == (slow_i ? 4'h6 : 4'h1))
      begin
        ack_o    <= 1'b1;
        cs_o     <= {6'h00, addr_i};
        ip_o     <= ~{6'h00, addr_i};
        wait_cnt <= 4'h0;
      end
      else
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : cie_vec_table

//--- test/tb.sv
`timescale 1ns/10ps
module tb;
  import cie_pkg::*;
  // -------------------------------------------------
  // Stimulus and observed signals
  // -------------------------------------------------
  logic        clk_i = 0, rst_b_i = 0, system_init_input_n_i = 0, slow = 0;
  logic        psel_i = 0, penable_i = 0, pwrite_i = 0, instr_done_i = 0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, rd, er;
  logic [7:0]  opcode_i = 8'h90, soft_type_i = '0;
  logic [15:0] instr_ip_i = '0, prefix_ip_i = '0, next_ip_i = '0, cur_cs_i = '0;
  logic [15:0] limit_index_i = 16'h0015, limit_lo_i = 16'h000A, limit_hi_i = 16'h0014;
  logic [15:0] int_return_sw_i = '0, sw_data_i = '0, sw = 16'hF002;
  logic        nonmaskable_request_i = 0;
  logic [2:0]  timer_req_i = '0;
  logic [1:0]  dma_req_i = '0;
  logic [3:0]  external_request_lines_i = '0;
  logic [13:0] cz = '0;
  wire         esc_prefix_i, sw_write_i, int_return_i, instr_numeric_i, instr_wait_i;
  wire         instr_seg_write_i, instr_prefix_i, coproc_error_i, soft_int_i, breakpoint_i;
  wire         overflow_trap_i, limit_check_i, undef_opcode_i, div_overflow_i, vec_ack_i;
  wire  [15:0] vec_cs_i, vec_ip_i;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, core_hold_o, fetch_valid_o, push_valid_o, vec_req_o;
  logic [19:0] fetch_addr_o, fa;
  logic [15:0] push_data_o, status_word_o;
  logic [9:0]  vec_addr_o, va;
  logic [8:0]  src_ack_o;
  logic [15:0] gq[$];
  logic [31:0] seed = 32'h8876;
  logic        fseen = 0;
  int          miscompares = 0, samples_checked = 0, cyc = 0;
  int          ml[5] = '{18, 19, 10, 11, 15};
  logic [13:0] cl[6] = '{14'h0001, 14'h0002, 14'h0004, 14'h0010, 14'h0440, 14'h0040};
  int          tl[6] = '{0, 6, 5, 3, 16, -1};

  // Cause word, one bit per input, fans out to the qualifying inputs
  assign {esc_prefix_i, sw_write_i, int_return_i, instr_numeric_i, instr_wait_i,
          instr_seg_write_i, instr_prefix_i, coproc_error_i, soft_int_i, breakpoint_i,
          overflow_trap_i, limit_check_i, undef_opcode_i, div_overflow_i} = cz;

  cie_core dut (.*);
  cie_vec_table vt (.clk_i(clk_i), .req_i(vec_req_o), .addr_i(vec_addr_o), .slow_i(slow),
                    .ack_o(vec_ack_i), .cs_o(vec_cs_i), .ip_o(vec_ip_i));

  initial forever #2 clk_i = ~clk_i;

  // -------------------------------------------------
  // Helpers
  // -------------------------------------------------
  function automatic logic [15:0] rnd;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i    <= 1'b1;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd        = prdata_o;
    er        = {31'h0, pslverr_o};
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  // Flag write is one completed instruction, so it needs the done strobe
  task automatic setsw(input logic [15:0] v);
    @(posedge clk_i);
    cz           <= 14'h1000;
    instr_done_i <= 1'b1;
    sw_data_i    <= v;
    @(posedge clk_i);
    cz           <= '0;
    instr_done_i <= 1'b0;
    sw           = v;
  endtask : setsw

  // Completes one instruction; ty < 0 means no entry may follow
  task automatic fire(input logic [13:0] c, input int ty);
    logic [15:0] cs, ip, ri;
    logic [15:0] e[3];
    int          n;
    cs = rnd();
    ip = rnd();
    ri = c[13] ? ip - 16'h0003 : (ty == 7 ? ip - 16'h0002 : ip);
    e  = '{sw, cs, ri};
    @(posedge clk_i);
    cz           <= c;
    instr_done_i <= 1'b1;
    cur_cs_i     <= cs;
    next_ip_i    <= ip;
    instr_ip_i   <= ip - 16'h0002;
    prefix_ip_i  <= ip - 16'h0003;
    slow         <= seed[3];
    gq.delete();
    fseen = 0;
    @(posedge clk_i);
    cz           <= '0;
    instr_done_i <= 1'b0;
    n = 0;
    while (!fseen && n < 60)
    begin
      @(posedge clk_i);
      n++;
    end
    if (ty < 0)
      chk(gq.size(), 0);
    else
    begin
      chk(va, ty * 4);
      chk(fa, 20'(((ty * 4) << 4) + (16'hFFFF ^ (ty * 4))));
      chk(gq.size(), 3);
      foreach (e[i]) chk(gq[i], e[i]);
      sw[9:8] = 2'b00;
      @(posedge clk_i);
      chk(status_word_o, sw);
    end
  endtask : fire

  // -------------------------------------------------
  // Monitor, request release on acknowledge, timeout
  // -------------------------------------------------
  always @(posedge clk_i)
  begin
    cyc++;
    if (push_valid_o) gq.push_back(push_data_o);
    if (vec_req_o && vec_ack_i) va = vec_addr_o;
    if (fetch_valid_o) fa = fetch_addr_o;
    if (fetch_valid_o) fseen = 1;
    if (|src_ack_o)
    begin
      timer_req_i              <= timer_req_i & ~src_ack_o[2:0];
      dma_req_i                <= dma_req_i & ~src_ack_o[4:3];
      external_request_lines_i <= external_request_lines_i & ~src_ack_o[8:5];
    end
    if (cyc > 6000)
    begin
      miscompares++;
      final_report();
    end
  end

  // -------------------------------------------------
  // Scenarios
  // -------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(core_hold_o, 1);
    system_init_input_n_i <= 1'b1;
    while (!fseen && cyc < 40) @(posedge clk_i);
    chk(fa, FETCH_RST);
    chk(status_word_o, SW_RST);
    apb(0, OFF_RELOC, 0);
    chk(rd, {16'h0, RELOC_RST});
    apb(0, OFF_UMCS, 0);
    chk(rd, {16'h0, UMCS_RST});
    apb(0, 12'h040, 0);
    chk(er, 1);
    foreach (cl[i]) fire(cl[i], tl[i]);
    limit_index_i <= 16'h0014;
    fire(14'h0004, -1);
    fire(14'h0008, -1);
    setsw(16'h0800);
    fire(14'h0008, 4);
    setsw(16'h0100);
    fire(14'h0080, -1);
    fire(14'h0100, -1);
    fire(14'h0200, -1);
    fire(14'h0000, 1);
    opcode_i <= ESC_LO + {5'h00, seed[2:0]};
    fire(14'h0000, 7);
    fire(14'h2000, 7);
    apb(1, OFF_CTRL, 1);
    fire(14'h0000, -1);
    apb(1, OFF_RELOC, 32'h0000_60FF);
    fire(14'h0000, 7);
    opcode_i <= 8'h90;
    nonmaskable_request_i <= 1'b1;
    fire(14'h0000, 2);
    nonmaskable_request_i <= 1'b0;
    setsw(16'h0200);
    timer_req_i <= 3'b110;
    dma_req_i <= 2'b11;
    external_request_lines_i <= 4'b1000;
    soft_type_i <= 8'h40;
    fire(14'h0020, 64);
    foreach (ml[i])
    begin
      sw = 16'h0200;
      int_return_sw_i <= sw;
      fire(14'h0800, ml[i]);
    end
    apb(1, OFF_CTRL, 2);
    apb(1, OFF_SVEC, 32'h0060_0000);
    dma_req_i <= 2'b01;
    sw = 16'h0200;
    fire(14'h0800, 96);
    // Unique programmed levels: line 3 lowest number, timer group highest
    apb(1, OFF_PRIO, 32'h0000_A72E);
    apb(0, OFF_PRIO, 0);
    chk(rd, 32'h0000_A72E);
    timer_req_i <= 3'b001;
    external_request_lines_i <= 4'b1000;
    sw = 16'h0200;
    fire(14'h0800, 15);
    sw = 16'h0200;
    fire(14'h0800, 8);
    final_report();
  end
endmodule : tb
